// file: spio_pad_model.sv
`timescale 1ns/10ps
`default_nettype none
module spio_pad_model
  import spio_pkg::*;
(
  input wire spio_pad_out_t pad,
  input wire spio_word_t ext,
  output spio_word_t level
);
  // a driven pad shows its driver, a released pad only the outside level
  assign level = (pad.data & ~pad.oe_n) | (ext & pad.oe_n);
endmodule
`default_nettype wire

// file: spio_params.svh
`ifndef SPIO_PARAMS_SVH
`define SPIO_PARAMS_SVH
// port geometry
`define SPIO_WIDTH 16
// register byte offsets on the bus
`define SPIO_OFF_DIR 8'h00
`define SPIO_OFF_PIN 8'h04
`define SPIO_OFF_LAT 8'h08
`define SPIO_OFF_ANA 8'h0c
`define SPIO_OFF_IMPL 8'h10
// reset values
`define SPIO_DIR_RST 16'hffff
`define SPIO_LAT_RST 16'h0000
`define SPIO_ANA_RST 16'h0000
// default implemented-bit mask, arbitrary
`define SPIO_IMPL_DEF 16'hffff
// axi response codes
`define SPIO_RESP_OKAY 2'b00
`define SPIO_RESP_SLVERR 2'b10
`endif

// file: spio_pkg.sv
`include "spio_params.svh"
package spio_pkg;
  typedef logic [`SPIO_WIDTH-1:0] spio_word_t;
  // per-pad output pair handed to the pad cell
  typedef struct packed {
    spio_word_t data;
    spio_word_t oe_n;
  } spio_pad_out_t;
  // peripheral request for pad ownership
  typedef struct packed {
    spio_word_t own;
    spio_word_t data;
    spio_word_t oe_n;
  } spio_periph_t;
  typedef enum logic [1:0] {SPIO_RD_IDLE, SPIO_RD_RESP} spio_rd_state_t;
  typedef enum logic [1:0] {SPIO_WR_IDLE, SPIO_WR_RESP} spio_wr_state_t;
endpackage

// file: spio_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "spio_params.svh"
module spio_port
  import spio_pkg::*;
#(
  parameter spio_word_t IMPL_MASK = `SPIO_IMPL_DEF
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire spio_periph_t PERIPH,
  input wire spio_word_t PAD_IN,
  output spio_pad_out_t PAD_OUT,
  output spio_word_t ANALOG_PATH_EN
);

  // byte-lane merge of a 16-bit register
  function automatic spio_word_t merge16(input spio_word_t old, input logic [31:0] wd,
                                         input logic [3:0] st);
    spio_word_t r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // decode shared by both bus directions
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  spio_word_t direction_reg, direction_next;
  spio_word_t output_latch_reg, output_latch_next;
  spio_word_t analog_pin_config_reg, analog_pin_config_next;
  spio_word_t pin_sync_reg, pin_sync_next;
  spio_word_t pin_read_reg, pin_read_next;
  spio_wr_state_t wr_state_reg, wr_state_next;
  spio_rd_state_t rd_state_reg, rd_state_next;
  logic aw_got_reg, aw_got_next;
  logic w_got_reg, w_got_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  spio_word_t port_oe_n;

  // channel readiness; address and data may arrive in either order
  assign S_AXI_AWREADY = (wr_state_reg == SPIO_WR_IDLE) && !aw_got_reg;
  assign S_AXI_WREADY = (wr_state_reg == SPIO_WR_IDLE) && !w_got_reg;
  assign S_AXI_BVALID = wr_state_reg == SPIO_WR_RESP;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = rd_state_reg == SPIO_RD_IDLE;
  assign S_AXI_RVALID = rd_state_reg == SPIO_RD_RESP;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // write channel capture and register update
  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    wr_state_next = wr_state_reg;
    bresp_next = bresp_reg;
    direction_next = direction_reg;
    output_latch_next = output_latch_reg;
    analog_pin_config_next = analog_pin_config_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_next = 1'b1;
      awaddr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_next = 1'b1;
      wdata_next = S_AXI_WDATA;
      wstrb_next = S_AXI_WSTRB;
    end
    unique case (wr_state_reg)
      SPIO_WR_IDLE: begin
        if (aw_got_reg && w_got_reg) begin
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
          wr_state_next = SPIO_WR_RESP;
          bresp_next = `SPIO_RESP_OKAY;
          if (addr_hit(awaddr_reg, `SPIO_OFF_DIR)) begin
            // unimplemented bits forced to zero
            direction_next = merge16(direction_reg, wdata_reg, wstrb_reg) & IMPL_MASK;
          end else if (addr_hit(awaddr_reg, `SPIO_OFF_LAT) ||
                       addr_hit(awaddr_reg, `SPIO_OFF_PIN)) begin
            // pin register writes land in the latch
            output_latch_next = merge16(output_latch_reg, wdata_reg, wstrb_reg)
                                & IMPL_MASK;
          end else if (addr_hit(awaddr_reg, `SPIO_OFF_ANA)) begin
            analog_pin_config_next = merge16(analog_pin_config_reg, wdata_reg, wstrb_reg)
                                     & IMPL_MASK;
          end else if (!addr_hit(awaddr_reg, `SPIO_OFF_IMPL)) begin
            bresp_next = `SPIO_RESP_SLVERR;
          end
        end
      end
      SPIO_WR_RESP: begin
        if (S_AXI_BREADY) begin
          wr_state_next = SPIO_WR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_state_reg <= SPIO_WR_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bresp_reg <= `SPIO_RESP_OKAY;
      direction_reg <= `SPIO_DIR_RST & IMPL_MASK;
      output_latch_reg <= `SPIO_LAT_RST;
      analog_pin_config_reg <= `SPIO_ANA_RST;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
      direction_reg <= direction_next;
      output_latch_reg <= output_latch_next;
      analog_pin_config_reg <= analog_pin_config_next;
    end
  end

  // pad muxes: owning peripheral wins both data and enable
  assign port_oe_n = direction_reg | ~IMPL_MASK;
  genvar g;
  generate
    for (g = 0; g < `SPIO_WIDTH; g++) begin : g_pad
      // input-only peripherals never assert own, so the port keeps the pad
      assign PAD_OUT.data[g] = PERIPH.own[g] ? PERIPH.data[g]
                                             : output_latch_reg[g];
      assign PAD_OUT.oe_n[g] = PERIPH.own[g] ? PERIPH.oe_n[g]
                                             : port_oe_n[g];
    end
  endgenerate

  // converter sees every implemented analog pin, whatever its direction or driver
  assign ANALOG_PATH_EN = analog_pin_config_reg & IMPL_MASK;

  // two-stage pin sampling; reads see pins two cycles after a change settles
  always_comb begin
    pin_sync_next = PAD_IN;
    // pad reads work even when a peripheral drives the pin
    pin_read_next = pin_sync_reg & ~analog_pin_config_reg & IMPL_MASK;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_sync_reg <= '0;
      pin_read_reg <= '0;
    end else begin
      pin_sync_reg <= pin_sync_next;
      pin_read_reg <= pin_read_next;
    end
  end

  // read channel; data captured at address accept
  always_comb begin
    rd_state_next = rd_state_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    unique case (rd_state_reg)
      SPIO_RD_IDLE: begin
        if (S_AXI_ARVALID) begin
          rd_state_next = SPIO_RD_RESP;
          rresp_next = `SPIO_RESP_OKAY;
          rdata_next = 32'h0000_0000;
          if (addr_hit(S_AXI_ARADDR, `SPIO_OFF_DIR)) begin
            rdata_next[15:0] = direction_reg;
          end else if (addr_hit(S_AXI_ARADDR, `SPIO_OFF_PIN)) begin
            rdata_next[15:0] = pin_read_reg;
          end else if (addr_hit(S_AXI_ARADDR, `SPIO_OFF_LAT)) begin
            rdata_next[15:0] = output_latch_reg;
          end else if (addr_hit(S_AXI_ARADDR, `SPIO_OFF_ANA)) begin
            rdata_next[15:0] = analog_pin_config_reg;
          end else if (addr_hit(S_AXI_ARADDR, `SPIO_OFF_IMPL)) begin
            rdata_next[15:0] = IMPL_MASK;
          end else begin
            rresp_next = `SPIO_RESP_SLVERR;
          end
        end
      end
      SPIO_RD_RESP: begin
        if (S_AXI_RREADY) begin
          rd_state_next = SPIO_RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_state_reg <= SPIO_RD_IDLE;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `SPIO_RESP_OKAY;
    end else begin
      rd_state_reg <= rd_state_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

endmodule
`default_nettype wire

// file: spio_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "spio_params.svh"
module spio_port_bench
  import spio_pkg::*;
;
  logic clk, rst, awv, awr, wv, wrd, bv, bre, arv, arr, rv, rre;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic [1:0] br, rr;
  spio_periph_t per;
  spio_word_t ext, pin, aen;
  spio_pad_out_t pout;
  int errors, samples_checked;
  spio_port #(.IMPL_MASK(16'h0fff)) dut (.CLK(clk), .SYS_RST(rst),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rre), .PERIPH(per), .PAD_IN(pin), .PAD_OUT(pout), .ANALOG_PATH_EN(aen));
  spio_pad_model pads (.pad(pout), .ext(ext), .level(pin));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // handshakes judged on values sampled at the rising edge, before the design updates
  task xfer(input bit isrd, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic [1:0] r);
    int n;
    bit dn;
    dn = 0;
    q = 32'h0;
    r = 2'h0;
    if (isrd) begin
      ara <= a;
      arv <= 1;
      rre <= 1;
    end else begin
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bre <= 1;
    end
    for (n = 0; n < 40 && !dn; n++) begin
      @(posedge clk);
      if (isrd) begin
        if (arv && arr) arv <= 0;
        dn = rv && rre;
        q = rd;
        r = rr;
      end else begin
        if (awv && awr) awv <= 0;
        if (wv && wrd) wv <= 0;
        dn = bv && bre;
        r = br;
      end
      if (dn) begin
        bre <= 0;
        rre <= 0;
      end
    end
    if (!dn) begin
      errors++;
      tally_and_finish();
    end else begin
      @(posedge clk);
    end
  endtask
  // extra edges let the pads pass the synchroniser before the next read
  task wx(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0] r;
    xfer(0, a, d, q, r);
    chk("write resp", {30'h0, r}, {30'h0, `SPIO_RESP_OKAY});
    repeat (2) @(posedge clk);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic [1:0] r;
    xfer(1, a, 32'h0, q, r);
    chk("read data", q, e);
  endtask
  initial begin
    logic [31:0] q;
    logic [1:0] r;
    rst = 1; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; awa = 0; ara = 0; wd = 0;
    ws = 4'h3; per = '0; ext = 16'h1234; errors = 0; samples_checked = 0;
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rc(`SPIO_OFF_DIR, 32'h0fff);
    rc(`SPIO_OFF_PIN, 32'h0234);
    $display("reset test done");
    wx(`SPIO_OFF_LAT, 32'ha5a5);
    rc(`SPIO_OFF_LAT, 32'h05a5);
    wx(`SPIO_OFF_PIN, 32'h3c3c);
    rc(`SPIO_OFF_LAT, 32'h0c3c);
    wx(`SPIO_OFF_DIR, 32'h0);
    rc(`SPIO_OFF_PIN, 32'h0c3c);
    chk("pad enable", {16'h0, pout.oe_n & 16'h0fff}, 32'h0);
    $display("latch test done");
    wx(`SPIO_OFF_ANA, 32'h000c);
    rc(`SPIO_OFF_PIN, 32'h0c30);
    chk("analog path", {16'h0, aen}, 32'h000c);
    wx(`SPIO_OFF_ANA, 32'h0);
    per <= '{16'h00ff, 16'h0055, 16'h0000};
    repeat (3) @(posedge clk);
    rc(`SPIO_OFF_PIN, 32'h0c55);
    per <= '0;
    repeat (3) @(posedge clk);
    rc(`SPIO_OFF_PIN, 32'h0c3c);
    $display("peripheral test done");
    xfer(0, 8'h20, 32'h1, q, r);
    chk("bad write resp", {30'h0, r}, {30'h0, `SPIO_RESP_SLVERR});
    xfer(1, 8'h20, 32'h0, q, r);
    chk("bad read resp", {30'h0, r}, {30'h0, `SPIO_RESP_SLVERR});
    chk("bad read data", q, 32'h0);
    $display("unmapped test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: spio_port_checker.sv
`timescale 1ns/10ps
`default_nettype none
module spio_port_checker
  import spio_pkg::*;
#(parameter spio_word_t IMPL_MASK = 16'hffff) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire spio_periph_t PERIPH,
  input wire spio_pad_out_t PAD_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // read steps: address taken, then answer taken
  sequence rd_take; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
  sequence rd_done; S_AXI_RVALID && S_AXI_RREADY; endsequence
  rd_answer_a: assert property (rd_take |=> S_AXI_RVALID)
    else $error("read answer missing");
  rd_close_a: assert property (rd_done |=> !S_AXI_RVALID)
    else $error("read answer not closed");
  rd_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while busy");
  rd_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("upper read bits set");
  wr_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("write taken while busy");
  own_enable_a: assert property ((PAD_OUT.oe_n & PERIPH.own) == (PERIPH.oe_n & PERIPH.own))
    else $error("owned pad enable wrong");
  own_data_a: assert property ((PAD_OUT.data & PERIPH.own) == (PERIPH.data & PERIPH.own))
    else $error("owned pad data wrong");
  // checked during reset itself, so no disable here
  reset_input_a: assert property (disable iff (1'b0) SYS_RST |->
    ((PAD_OUT.oe_n | PERIPH.own) & IMPL_MASK) == IMPL_MASK)
    else $error("pad driven in reset");
endmodule
bind spio_port spio_port_checker #(.IMPL_MASK(IMPL_MASK)) chk_i (
  .CLK(CLK), .SYS_RST(SYS_RST), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .PERIPH(PERIPH), .PAD_OUT(PAD_OUT));
`default_nettype wire
